// File: src/dmbc_defines.vh
// dmbc_defines.vh: offsets, field positions, reset values and codes of the
// multi-block dma channel controller; included by the channel design file and by the bench.
`ifndef DMBC_DEFINES_VH
`define DMBC_DEFINES_VH

// ****************************************************************
// register byte offsets on apb
// ****************************************************************
`define DMBC_OFF_SAR   8'h00
`define DMBC_OFF_DAR   8'h04
`define DMBC_OFF_LLP   8'h08
`define DMBC_OFF_CTL   8'h0C
`define DMBC_OFF_CFG   8'h10
`define DMBC_OFF_STAT  8'h14
`define DMBC_OFF_CMD   8'h18
`define DMBC_OFF_MASK  8'h1C

// ****************************************************************
// control register fields
// ****************************************************************
`define DMBC_CTL_INT_EN  0
`define DMBC_CTL_SBL_LO  1
`define DMBC_CTL_SBL_HI  3
`define DMBC_CTL_DBL_LO  4
`define DMBC_CTL_DBL_HI  6
`define DMBC_CTL_SLE     7
`define DMBC_CTL_DLE     8
`define DMBC_CTL_BTS_LO  9
`define DMBC_CTL_BTS_HI  20
`define DMBC_CTL_MASK    32'h001FFFFF

// ****************************************************************
// config and command fields, pointer mask and reset word
// ****************************************************************
`define DMBC_CFG_SRL     0
`define DMBC_CFG_DRL     1
`define DMBC_CMD_START   0
`define DMBC_CMD_BCLR    1
`define DMBC_LLP_MASK    32'hFFFFFFFC
`define DMBC_RST_WORD    32'h00000000

// ****************************************************************
// descriptor word offsets in memory
// ****************************************************************
`define DMBC_DESC_SAR    32'h00000000
`define DMBC_DESC_DAR    32'h00000004
`define DMBC_DESC_LLP    32'h00000008
`define DMBC_DESC_CTL    32'h0000000C
`define DMBC_WORD_STEP   32'h00000004

`endif

// File: src/dmbc_req_sync.v
// dmbc_req_sync.v: two-flop resynchroniser and rising-edge detector for
// the active-low external request pin; pin is asynchronous to pclk.
`timescale 1ns/1ps
module dmbc_req_sync (
  input  wire pclk,
  input  wire presetn,
  input  wire ce,
  input  wire ext_req_in_n,
  output reg  req_level_r,
  output reg  req_rise_r
);
  reg meta_r;
  reg sync_r;

  // ****************************************************************
  // resynchroniser; only req_level_r and req_rise_r are looked at downstream
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r      <= 1'b0;
      sync_r      <= 1'b0;
      req_level_r <= 1'b0;
      req_rise_r  <= 1'b0;
    end else if (ce) begin
      meta_r      <= ~ext_req_in_n;
      sync_r      <= meta_r;
      req_level_r <= sync_r;
      req_rise_r  <= sync_r & ~req_level_r;
    end
  end
endmodule // dmbc_req_sync

// File: src/dmbc_channel.v
// dmbc_channel.v: one dma channel, external request handshake and
// multi-block sequencing, with an apb register slave and a descriptor
// memory port. assumes a memory that answers mem_req with mem_ack.
// Functional notes
// - resynchronise the request pin first
// - start transfer on synchronised request rising edge
// - drive acknowledge when transfer completed
// - addresses list/reload/contiguous; control list/reload
// - linked list: fetch descriptor before each block
// - fetch loads all four descriptor words; the code loads the address words only when their list bit is set
// - write back control on block completion
// - zero pointer, no bits: single, no update
// - nonzero pointer, no bits: last, write back
// - zero pointer, reload: reload control and pointer
// - reload restores initial values per block
// - reload with unmasked interrupt stalls until clear
// - rows one/five at block end terminate
`timescale 1ns/1ps
`include "dmbc_defines.vh"
module dmbc_channel (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ext_req_in_n,
  output reg         ext_xfer_ack_out,
  output reg         mem_req,
  output reg         mem_we,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  input  wire [31:0] mem_rdata,
  input  wire        mem_ack,
  output reg         busy
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_FETCH = 3'd1;
  localparam ST_WAIT  = 3'd2;
  localparam ST_XFER  = 3'd3;
  localparam ST_WB    = 3'd4;
  localparam ST_NEXT  = 3'd5;
  localparam ST_STALL = 3'd6;

  reg  [31:0] source_address_reg;
  reg  [31:0] dest_address_reg;
  reg  [31:0] next_descriptor_pointer;
  reg  [31:0] channel_control_reg;
  reg  [1:0]  channel_config_reg;
  reg         block_irq_mask;
  reg  [31:0] sh_sar_r;
  reg  [31:0] sh_dar_r;
  reg  [31:0] sh_llp_r;
  reg  [31:0] sh_ctl_r;
  reg  [31:0] cur_desc_r;
  reg  [2:0]  state_r;
  reg  [1:0]  word_r;
  reg  [11:0] left_r;
  reg  [6:0]  beat_r;
  reg         blk_done_r;
  reg         done_r;
  reg  [15:0] blk_cnt_r;
  wire        req_level;
  wire        req_rise;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function [6:0] burst_beats;
    input [2:0] code;
    begin
      if (code == 3'd0)
        burst_beats = 7'd1;
      else
        burst_beats = 7'd2 << code[1:0];
    end
  endfunction

  function is_reg;
    input [7:0] a;
    begin
      is_reg = (a[1:0] == 2'b00) && (a <= `DMBC_OFF_MASK);
    end
  endfunction

  // ****************************************************************
  // row decode from the list-enable and reload bits
  // ****************************************************************
  wire        loc_nz  = |next_descriptor_pointer[31:2];
  wire        s_list  = channel_control_reg[`DMBC_CTL_SLE];
  wire        d_list  = channel_control_reg[`DMBC_CTL_DLE];
  wire        s_rld   = channel_config_reg[`DMBC_CFG_SRL];
  wire        d_rld   = channel_config_reg[`DMBC_CFG_DRL];
  wire        any_lst = s_list | d_list;
  wire        any_rld = s_rld | d_rld;
  wire        last_row = ~any_lst & ~any_rld;
  wire        int_on  = channel_control_reg[`DMBC_CTL_INT_EN] & ~block_irq_mask;
  wire [11:0] bts     = channel_control_reg[`DMBC_CTL_BTS_HI:`DMBC_CTL_BTS_LO];
  wire [6:0]  beats   = burst_beats(channel_control_reg[`DMBC_CTL_SBL_HI:`DMBC_CTL_SBL_LO]);
  wire        apb_acc = psel & penable & pready;
  wire        apb_wr  = apb_acc & pwrite & is_reg(paddr);
  wire        cmd_wr  = apb_wr & (paddr == `DMBC_OFF_CMD);
  wire        start   = cmd_wr & pwdata[`DMBC_CMD_START] & (state_r == ST_IDLE);
  wire        bclr    = cmd_wr & pwdata[`DMBC_CMD_BCLR];
  wire        blk_end = (state_r == ST_XFER) && (left_r == 12'd1);
  wire        trn_end = (state_r == ST_XFER) && ((beat_r == 7'd1) || (left_r == 12'd1));

  dmbc_req_sync u_sync (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .ext_req_in_n (ext_req_in_n),
    .req_level_r  (req_level),
    .req_rise_r   (req_rise)
  );

  // ****************************************************************
  // apb slave: one wait state, write lands at the completing edge
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `DMBC_RST_WORD;
    end else if (ce) begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~is_reg(paddr);
      if (psel & penable & ~pready & ~pwrite) begin
        case (paddr)
          `DMBC_OFF_SAR:  prdata <= source_address_reg;
          `DMBC_OFF_DAR:  prdata <= dest_address_reg;
          `DMBC_OFF_LLP:  prdata <= next_descriptor_pointer;
          `DMBC_OFF_CTL:  prdata <= channel_control_reg;
          `DMBC_OFF_CFG:  prdata <= {30'd0, channel_config_reg};
          `DMBC_OFF_STAT: prdata <= {blk_cnt_r, 10'd0, req_level, done_r,
                                     blk_done_r, state_r};
          `DMBC_OFF_MASK: prdata <= {31'd0, block_irq_mask};
          default:        prdata <= `DMBC_RST_WORD;
        endcase
      end else begin
        prdata <= `DMBC_RST_WORD;
      end
    end
  end

  // ****************************************************************
  // channel sequencer
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_address_reg      <= `DMBC_RST_WORD;
      dest_address_reg        <= `DMBC_RST_WORD;
      next_descriptor_pointer <= `DMBC_RST_WORD;
      channel_control_reg     <= `DMBC_RST_WORD;
      channel_config_reg      <= 2'b00;
      block_irq_mask          <= 1'b0;
      sh_sar_r                <= `DMBC_RST_WORD;
      sh_dar_r                <= `DMBC_RST_WORD;
      sh_llp_r                <= `DMBC_RST_WORD;
      sh_ctl_r                <= `DMBC_RST_WORD;
      cur_desc_r              <= `DMBC_RST_WORD;
      state_r                 <= ST_IDLE;
      word_r                  <= 2'd0;
      left_r                  <= 12'd0;
      beat_r                  <= 7'd0;
      blk_done_r              <= 1'b0;
      done_r                  <= 1'b0;
      blk_cnt_r               <= 16'd0;
      ext_xfer_ack_out        <= 1'b0;
      mem_req                 <= 1'b0;
      mem_we                  <= 1'b0;
      mem_addr                <= `DMBC_RST_WORD;
      mem_wdata               <= `DMBC_RST_WORD;
      busy                    <= 1'b0;
    end else if (ce) begin
      // software writes; address, pointer and control registers are frozen while the channel runs
      if (apb_wr && state_r == ST_IDLE) begin
        case (paddr)
          `DMBC_OFF_SAR: source_address_reg      <= pwdata;
          `DMBC_OFF_DAR: dest_address_reg        <= pwdata;
          `DMBC_OFF_LLP: next_descriptor_pointer <= pwdata & `DMBC_LLP_MASK;
          `DMBC_OFF_CTL: channel_control_reg     <= pwdata & `DMBC_CTL_MASK;
          default: ;
        endcase
      end
      // reload bits stay writable mid-transfer so the isr can end the chain
      if (apb_wr && paddr == `DMBC_OFF_CFG)
        channel_config_reg <= pwdata[1:0];
      if (apb_wr && paddr == `DMBC_OFF_MASK)
        block_irq_mask <= pwdata[0];
      // block flag: a new block end wins over a clear in the same cycle
      if (blk_end)
        blk_done_r <= 1'b1;
      else if (bclr)
        blk_done_r <= 1'b0;
      // ack held from transaction end until the request is withdrawn
      if (trn_end)
        ext_xfer_ack_out <= 1'b1;
      else if (!req_level)
        ext_xfer_ack_out <= 1'b0;
      busy <= (state_r != ST_IDLE) | start;

      case (state_r)
        ST_IDLE: begin
          if (start) begin
            sh_sar_r   <= source_address_reg;
            sh_dar_r   <= dest_address_reg;
            sh_llp_r   <= next_descriptor_pointer;
            sh_ctl_r   <= channel_control_reg;
            cur_desc_r <= next_descriptor_pointer;
            done_r     <= 1'b0;
            blk_cnt_r  <= 16'd0;
            word_r     <= 2'd0;
            if (loc_nz && any_lst) begin
              state_r  <= ST_FETCH;
              mem_req  <= 1'b1;
              mem_we   <= 1'b0;
              mem_addr <= next_descriptor_pointer + `DMBC_DESC_SAR;
            end else begin
              state_r  <= ST_WAIT;
              left_r   <= bts;
            end
          end
        end
        ST_FETCH: begin
          if (mem_ack) begin
            // all four words are read; addresses land only if list-updated
            case (word_r)
              2'd0: if (s_list) source_address_reg <= mem_rdata;
              2'd1: if (d_list) dest_address_reg <= mem_rdata;
              2'd2: next_descriptor_pointer <= mem_rdata & `DMBC_LLP_MASK;
              default: channel_control_reg <= mem_rdata & `DMBC_CTL_MASK;
            endcase
            word_r   <= word_r + 2'd1;
            mem_addr <= mem_addr + `DMBC_WORD_STEP;
            if (word_r == 2'd2)
              cur_desc_r <= mem_addr - `DMBC_DESC_LLP;
            if (word_r == 2'd3) begin
              mem_req <= 1'b0;
              left_r  <= mem_rdata[`DMBC_CTL_BTS_HI:`DMBC_CTL_BTS_LO];
              state_r <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (left_r == 12'd0) begin
            state_r <= ST_NEXT;
          end else if (req_rise) begin
            state_r <= ST_XFER;
            beat_r  <= beats;
          end
        end
        ST_XFER: begin
          // addresses walk on, giving the contiguous case for free
          source_address_reg <= source_address_reg + `DMBC_WORD_STEP;
          dest_address_reg   <= dest_address_reg + `DMBC_WORD_STEP;
          left_r             <= left_r - 12'd1;
          beat_r             <= beat_r - 7'd1;
          if (blk_end) begin
            blk_cnt_r <= blk_cnt_r + 16'd1;
            if (loc_nz) begin
              state_r   <= ST_WB;
              mem_req   <= 1'b1;
              mem_we    <= 1'b1;
              mem_addr  <= cur_desc_r + `DMBC_DESC_CTL;
              mem_wdata <= channel_control_reg;
            end else begin
              state_r <= ST_NEXT;
            end
          end else if (trn_end) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WB: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            state_r <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          // row sampled once at block end; reloads land before any stall
          if (last_row) begin
            state_r <= ST_IDLE;
            done_r  <= 1'b1;
          end else begin
            if (s_rld)
              source_address_reg <= sh_sar_r;
            if (d_rld)
              dest_address_reg <= sh_dar_r;
            if (!any_lst) begin
              channel_control_reg     <= sh_ctl_r;
              next_descriptor_pointer <= sh_llp_r;
              left_r                  <= sh_ctl_r[`DMBC_CTL_BTS_HI:`DMBC_CTL_BTS_LO];
            end
            if (any_rld && int_on && blk_done_r) begin
              state_r <= ST_STALL;
            end else if (!any_lst) begin
              state_r <= ST_WAIT;
            end else begin
              state_r  <= ST_FETCH;
              word_r   <= 2'd0;
              mem_req  <= 1'b1;
              mem_we   <= 1'b0;
              mem_addr <= next_descriptor_pointer + `DMBC_DESC_SAR;
            end
          end
        end
        ST_STALL: begin
          // held until the clear write; the isr's new row counts at the next end
          if (!blk_done_r && !any_lst) begin
            state_r <= ST_WAIT;
          end else if (!blk_done_r) begin
            state_r  <= ST_FETCH;
            word_r   <= 2'd0;
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= next_descriptor_pointer + `DMBC_DESC_SAR;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // dmbc_channel

// File: testbench/dmbc_checker.sv
// dmbc_checker.sv: port assertions for dmbc_channel.
// assumes one pclk domain, presetn async active low, ce held high.
`timescale 1ns/1ps
module dmbc_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [7:0]  paddr,
  input wire        pready,
  input wire        pslverr,
  input wire        ext_req_in_n,
  input wire        ext_xfer_ack_out,
  input wire        mem_req,
  input wire        mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire        mem_ack
);
  // ****
  // fetch word counter
  // ****
  reg [2:0] fw_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      fw_r <= 3'h0;
    else if (!mem_req)
      fw_r <= 3'h0;
    else if (mem_ack && !mem_we)
      fw_r <= fw_r + 3'h1;
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_low3; !ext_req_in_n [*3]; endsequence
  sequence s_high6; ext_req_in_n [*6]; endsequence
  sequence s_rdack; mem_req && mem_ack && !mem_we; endsequence
  property p_ack_sync; $rose(ext_req_in_n) && ext_xfer_ack_out |=> ext_xfer_ack_out; endproperty
  property p_ack_cause; $rose(ext_xfer_ack_out) |-> !$past(ext_req_in_n, 3); endproperty
  property p_ack_hold; s_low3 ##0 ext_xfer_ack_out |=> ext_xfer_ack_out; endproperty
  property p_ack_drop; s_high6 |-> !ext_xfer_ack_out; endproperty
  property p_fetch_step;
    s_rdack ##0 fw_r < 3'h3 |=> mem_req && !mem_we && mem_addr == $past(mem_addr) + 32'h4;
  endproperty
  property p_fetch_end; s_rdack ##0 fw_r == 3'h3 |=> !mem_req; endproperty
  property p_wb_one; mem_req && mem_ack && mem_we |=> !mem_req; endproperty
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata);
  endproperty
  property p_apb_wait; psel && penable && !pready |=> pready; endproperty
  property p_apb_err; pready |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0); endproperty
  a_ack_sync: assert property (p_ack_sync)
    else $error("ack fell before request could pass the synchroniser");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack rose without a held request");
  a_ack_hold: assert property (p_ack_hold)
    else $error("ack dropped while request still low");
  a_ack_drop: assert property (p_ack_drop)
    else $error("ack stuck after request release");
  a_fetch_step: assert property (p_fetch_step)
    else $error("descriptor fetch not on next word");
  a_fetch_end: assert property (p_fetch_end)
    else $error("fetch longer than four words");
  a_wb_one: assert property (p_wb_one)
    else $error("write-back longer than one word");
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request changed before ack");
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb wait state wrong");
  a_apb_err: assert property (p_apb_err)
    else $error("apb error flag wrong");
endmodule // dmbc_chk
bind dmbc_channel dmbc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .ext_req_in_n(ext_req_in_n), .ext_xfer_ack_out(ext_xfer_ack_out), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack));

// File: testbench/dmbc_peer.sv
// dmbc_peer.sv: external request peripheral and descriptor memory.
// assumes the bench raises want when the fifo crosses its watermark.
`timescale 1ns/1ps
module dmbc_peer (
  input  wire        pclk,
  input  wire        want,
  input  wire        slow,
  output logic       ext_req_in_n,
  input  wire        ext_xfer_ack_out,
  input  wire        mem_req,
  input  wire        mem_we,
  input  wire [31:0] mem_addr,
  input  wire [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic       mem_ack
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] last_wa;
  logic        tg;
  int          n_ack;
  int          n_wr;
  int          t;
  initial begin
    ext_req_in_n = 1'b1;
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    tg = 1'b0;
    n_ack = 0;
    n_wr = 0;
  end
  // retry after a long silence: a level held during a stall is never seen
  always begin
    @(posedge pclk);
    if (want && ext_xfer_ack_out !== 1'b1) begin
      ext_req_in_n <= 1'b0;
      t = 0;
      while (ext_xfer_ack_out !== 1'b1 && t < 64) begin
        @(posedge pclk);
        t++;
      end
      ext_req_in_n <= 1'b1;
      if (t < 64)
        n_ack++;
      while (ext_xfer_ack_out === 1'b1)
        @(posedge pclk);
      repeat (3) @(posedge pclk);
    end
  end
  // one word per ack, released data inverted
  always @(posedge pclk) begin
    tg <= ~tg;
    if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_we) begin
        mem[mem_addr] = mem_wdata;
        last_wa = mem_addr;
        n_wr++;
      end
    end else if (mem_req && !(slow && tg)) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
    end
  end
endmodule // dmbc_peer

// File: testbench/tb_top.sv
// tb_top.sv: self-checking bench for dmbc_channel, apb master tasks.
// assumes dmbc_peer as peripheral and memory; pclk 100 MHz.
`timescale 1ns/1ps
`include "dmbc_defines.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        want, slow, req_n, ack, mreq, mwe, mack, busy, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, maddr, mwd, mrd, a, b;
  logic [15:0] rnd;
  int          fails, n_tests, cyc, k, a0, w0;
  dmbc_channel dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_req_in_n(req_n), .ext_xfer_ack_out(ack),
    .mem_req(mreq), .mem_we(mwe), .mem_addr(maddr), .mem_wdata(mwd), .mem_rdata(mrd),
    .mem_ack(mack), .busy(busy));
  dmbc_peer mdl (.pclk(pclk), .want(want), .slow(slow), .ext_req_in_n(req_n),
    .ext_xfer_ack_out(ack), .mem_req(mreq), .mem_we(mwe), .mem_addr(maddr),
    .mem_wdata(mwd), .mem_rdata(mrd), .mem_ack(mack));
  // ****
  // tasks
  // ****
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50)
      fails++;
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rr(input logic [7:0] ad);
    apb(1'b0, ad, 32'h0);
  endtask
  task run(input logic [31:0] s, d, l, c, g);
    apb(1'b1, `DMBC_OFF_SAR, s);
    apb(1'b1, `DMBC_OFF_DAR, d);
    apb(1'b1, `DMBC_OFF_LLP, l);
    apb(1'b1, `DMBC_OFF_CTL, c);
    apb(1'b1, `DMBC_OFF_CFG, g);
    apb(1'b1, `DMBC_OFF_MASK, 32'h0);
    // a block flag left by the last run would satisfy the status poll at once
    apb(1'b1, `DMBC_OFF_CMD, 32'h1 << `DMBC_CMD_BCLR);
    a0 = mdl.n_ack;
    w0 = mdl.n_wr;
    apb(1'b1, `DMBC_OFF_CMD, 32'h1 << `DMBC_CMD_START);
  endtask
  task idle;
    k = 0;
    while (busy !== 1'b0 && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    `CHK(busy, 1'b0)
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      conclude;
    end
  end
  // ****
  // tests
  // ****
  initial begin
    {presetn, psel, penable, pwrite, want, slow} = 6'h0;
    {paddr, pwdata, fails, n_tests, cyc} = 0;
    ce = 1'b1;
    rnd = 16'h4;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      rr(8'(i * 4));
      `CHK(rd, `DMBC_RST_WORD)
    end
    apb(1'b1, `DMBC_OFF_CTL, 32'hFFFFFFFF);
    rr(`DMBC_OFF_CTL);
    `CHK(rd, `DMBC_CTL_MASK)
    apb(1'b1, `DMBC_OFF_LLP, 32'hFFFFFFFF);
    rr(`DMBC_OFF_LLP);
    `CHK(rd, `DMBC_LLP_MASK)
    rr(8'h20);
    `CHK(e, 1'b1)
    $display("test regs done");
    want <= 1'b1;
    rnd = lfsr(rnd);
    a = {14'h0, rnd, 2'h0};
    b = a + 32'h4000;
    run(a, b, 32'h0, (32'd6 << 9) | (32'd1 << 1), 32'h0);
    idle;
    rr(`DMBC_OFF_SAR);
    `CHK(rd, a + 32'd24)
    rr(`DMBC_OFF_DAR);
    `CHK(rd, b + 32'd24)
    `CHK(mdl.n_ack - a0, 2)
    `CHK(mdl.n_wr - w0, 0)
    rr(`DMBC_OFF_STAT);
    `CHK(rd[4], 1'b1)
    `CHK(rd[31:16], 16'h0001)
    $display("test single done");
    slow <= 1'b1;
    rnd = lfsr(rnd);
    b = {14'h1, rnd, 2'h0};
    mdl.mem[32'h1000] = 32'h0;
    mdl.mem[32'h1004] = b;
    mdl.mem[32'h1008] = 32'h1010;
    mdl.mem[32'h100C] = (32'd2 << 9) | (32'd1 << 8);
    mdl.mem[32'h1010] = 32'h0;
    mdl.mem[32'h1014] = b + 32'h800;
    mdl.mem[32'h1018] = 32'h2000;
    mdl.mem[32'h101C] = 32'd3 << 9;
    run(a, 32'h0, 32'h1000, 32'd1 << 8, 32'h0);
    idle;
    rr(`DMBC_OFF_SAR);
    `CHK(rd, a + 32'd20)
    rr(`DMBC_OFF_DAR);
    `CHK(rd, b + 32'h80C)
    rr(`DMBC_OFF_LLP);
    `CHK(rd, 32'h2000)
    `CHK(mdl.n_ack - a0, 5)
    `CHK(mdl.last_wa, 32'h101C)
    `CHK(mdl.mem[32'h101C], 32'd3 << 9)
    $display("test linked done");
    slow <= 1'b0;
    run(a, b, 32'h0, (32'd2 << 9) | 32'h1, 32'h1 << `DMBC_CFG_SRL);
    rd = 32'h0;
    k = 0;
    while (rd[3] !== 1'b1 && k < 200) begin
      rr(`DMBC_OFF_STAT);
      k++;
    end
    `CHK(rd[3], 1'b1)
    repeat (30) @(posedge pclk);
    `CHK(busy, 1'b1)
    rr(`DMBC_OFF_SAR);
    `CHK(rd, a)
    rr(`DMBC_OFF_DAR);
    `CHK(rd, b + 32'd8)
    apb(1'b1, `DMBC_OFF_CFG, 32'h0);
    apb(1'b1, `DMBC_OFF_CMD, 32'h1 << `DMBC_CMD_BCLR);
    idle;
    rr(`DMBC_OFF_SAR);
    `CHK(rd, a + 32'd8)
    rr(`DMBC_OFF_DAR);
    `CHK(rd, b + 32'd16)
    `CHK(mdl.n_wr - w0, 0)
    $display("test reload done");
    conclude;
  end
endmodule // tb_top
